/* File: design/ssr_pkg.sv */
package ssr_pkg;

  // Bus geometry
  localparam int          ADR_W      = 8;
  localparam int          REG_W      = 16;
  localparam int          REG_COUNT  = 12;

  // Register indices; byte address is four times the index
  localparam logic [3:0]  IDX_STAB_TIME_SELECT = 4'h0;
  localparam logic [3:0]  IDX_PROG_STATUS_WORD = 4'h1;
  localparam logic [3:0]  IDX_CPU_CLOCK_CTRL   = 4'h2;
  localparam logic [3:0]  IDX_MEM_SIZE_SELECT  = 4'h3;
  localparam logic [3:0]  IDX_XRAM_SIZE_SELECT = 4'h4;
  localparam logic [3:0]  IDX_TIMER8_MODE_CTRL = 4'h5;
  localparam logic [3:0]  IDX_TIMER16_COUNT    = 4'h6;
  localparam logic [3:0]  IDX_TIMER16_CAPCMP   = 4'h7;
  localparam logic [3:0]  IDX_PERIPH_CTRL      = 4'h8;
  localparam logic [3:0]  IDX_PORT_LATCH       = 4'h9;
  localparam logic [3:0]  IDX_PORT_MODE        = 4'ha;
  localparam logic [3:0]  IDX_STATUS           = 4'hb;

  // Values loaded by reset processing
  localparam logic [15:0] RST_STAB_TIME_SELECT = 16'h0004;
  localparam logic [15:0] RST_PROG_STATUS_WORD = 16'h0002;
  localparam logic [15:0] RST_CPU_CLOCK_CTRL   = 16'h0004;
  localparam logic [15:0] RST_MEM_SIZE_SELECT  = 16'h00cf;
  localparam logic [15:0] RST_XRAM_SIZE_SELECT = 16'h000c;
  localparam logic [15:0] RST_TIMER8_MODE_CTRL = 16'h0004;
  localparam logic [15:0] RST_TIMER16          = 16'h0000;
  localparam logic [15:0] RST_CTRL_ZERO        = 16'h0000;
  localparam logic [15:0] RST_PORT_LATCH       = 16'h0000;
  localparam logic [15:0] RST_PORT_MODE        = 16'h00ff;

  localparam logic [15:0] RESET_VECTOR_ADDR    = 16'h0000;

  // Stabilisation: 2**17 main-clock periods after reset
  localparam int          RESET_STAB_LOG2      = 17;
  localparam int          CNT_W                = 18;

  localparam int          IRQ_N                = 8;

  typedef enum logic [2:0] {
    SSR_RUN, SSR_STOP, SSR_STAB_WAKE, SSR_RESET_HOLD, SSR_STAB_RESET
  } ssr_state_t;

  function automatic logic [15:0] ssr_reg_init(input logic [3:0] idx);
    case (idx)
      IDX_STAB_TIME_SELECT: ssr_reg_init = RST_STAB_TIME_SELECT;
      IDX_PROG_STATUS_WORD: ssr_reg_init = RST_PROG_STATUS_WORD;
      IDX_CPU_CLOCK_CTRL:   ssr_reg_init = RST_CPU_CLOCK_CTRL;
      IDX_MEM_SIZE_SELECT:  ssr_reg_init = RST_MEM_SIZE_SELECT;
      IDX_XRAM_SIZE_SELECT: ssr_reg_init = RST_XRAM_SIZE_SELECT;
      IDX_TIMER8_MODE_CTRL: ssr_reg_init = RST_TIMER8_MODE_CTRL;
      IDX_TIMER16_COUNT:    ssr_reg_init = RST_TIMER16;
      IDX_TIMER16_CAPCMP:   ssr_reg_init = RST_TIMER16;
      IDX_PORT_LATCH:       ssr_reg_init = RST_PORT_LATCH;
      IDX_PORT_MODE:        ssr_reg_init = RST_PORT_MODE;
      default:              ssr_reg_init = RST_CTRL_ZERO;
    endcase
  endfunction

  // Wake wait as a right shift of the reset wait: 2**12,14,15,16,17
  function automatic logic [2:0] ssr_wake_shift(input logic [2:0] sel);
    case (sel)
      3'h0:    ssr_wake_shift = 3'h5;
      3'h1:    ssr_wake_shift = 3'h3;
      3'h2:    ssr_wake_shift = 3'h2;
      3'h3:    ssr_wake_shift = 3'h1;
      default: ssr_wake_shift = 3'h0;
    endcase
  endfunction

endpackage

/* File: design/ssr_stop_reset.sv */
`timescale 1ns/100ps
// Function
// - Stop only from main clock
// - Crystal output pulled up during stop
// - Pending unmasked request falls back, waits, resumes
// - Stop halts main oscillator and CPU, not subsystem oscillator
// - Port latches held during stop
// - Listed peripherals halted during stop
// - 8-bit timers run on external input only
// - Watch timer runs on selected subsystem clock
// - Serial on external clock; external irqs live
// - Interrupt wake waits, then service or next
// - Mask, priority, enable, in-service decide wake action
// - Reset in stop: wait then reset processing
// - Reset from stop keeps contents, pins float
// - Pin and watchdog give identical reset
// - Start at reset vector address
// - Pins float in reset and wait
// - Pin release waits 2**17 main clocks
// - Watchdog reset self-clears, same wait
// - Main oscillator off, subsystem on, in reset
// - Core registers take reset values
// - Timer and control registers take reset values
// - Standby keeps registers and port state
module ssr_stop_reset
  import ssr_pkg::*;
#(
  parameter int RESET_STAB_CYCLES = 2 ** RESET_STAB_LOG2
) (
  // Clock, reset, enable
  input  wire logic               mclk_in,
  input  wire logic               reset_in,
  input  wire logic               clk_en_in,
  // Wishbone slave
  input  wire logic               wb_cyc_in,
  input  wire logic               wb_stb_in,
  input  wire logic               wb_we_in,
  input  wire logic [ADR_W-1:0]   wb_adr_in,
  input  wire logic [3:0]         wb_sel_in,
  input  wire logic [31:0]        wb_dat_in,
  output logic      [31:0]        wb_dat_out,
  output logic                    wb_ack_out,
  // Reset sources
  input  wire logic               ext_reset_n_in,
  input  wire logic               wdt_overflow_in,
  // CPU and interrupt controller
  input  wire logic               stop_exec_in,
  input  wire logic               cpu_on_subclk_in,
  input  wire logic [IRQ_N-1:0]   irq_req_in,
  input  wire logic [IRQ_N-1:0]   irq_mask_flag_in,
  input  wire logic [IRQ_N-1:0]   irq_priority_flag_in,
  input  wire logic               irq_global_enable_in,
  input  wire logic               in_service_priority_in,
  // Peripheral clock selections
  input  wire logic [1:0]         timer5_ext_sel_in,
  input  wire logic               subclk_present_in,
  input  wire logic               watch_sel_subclk_in,
  input  wire logic               three_wire_serial_ext_clk_in,
  // Clock generator and pins
  output logic                    main_osc_en_out,
  output logic                    sub_osc_en_out,
  output logic                    cpu_clk_en_out,
  output logic                    crystal_output_pin_pullup_out,
  output logic                    port_hiz_out,
  output logic [7:0]              port_latch_out,
  output logic [7:0]              port_mode_out,
  // Peripheral run enables
  output logic                    timer16_run_out,
  output logic                    wdt_run_out,
  output logic                    adc_run_out,
  output logic                    uart_run_out,
  output logic                    vehicle_net_run_out,
  output logic                    sound_run_out,
  output logic                    lcd_run_out,
  output logic [1:0]              timer8_run_out,
  output logic                    watch_run_out,
  output logic                    three_wire_serial_run_out,
  output logic                    ext_irq_detect_en_out,
  // CPU sequencing
  output logic                    core_reset_out,
  output logic                    pc_load_out,
  output logic [15:0]             reset_vector_addr_out,
  output logic                    irq_service_out,
  output logic                    next_instr_out
);

  ssr_state_t         state_q, state_d;
  logic [CNT_W-1:0]   cnt_q, cnt_d;
  logic               pin_meta_q, pin_sync_q;
  logic               from_stop_q, from_stop_d;
  logic               high_pri_q, high_pri_d;
  logic               ack_q;
  logic [31:0]        rdat_q;
  logic [REG_W-1:0]   regs_q [REG_COUNT];
  logic               svc_q, next_q, pcld_q;

  wire logic [IRQ_N-1:0] unmasked   = irq_req_in & ~irq_mask_flag_in;
  wire logic             pend       = |unmasked;
  wire logic             pend_high  = |(unmasked & ~irq_priority_flag_in);
  wire logic             reset_req  = !pin_sync_q || wdt_overflow_in;
  wire logic             stop_ok    = stop_exec_in && !cpu_on_subclk_in;
  wire logic [CNT_W-1:0] reset_wait = CNT_W'(RESET_STAB_CYCLES);
  wire logic [CNT_W-1:0] wake_wait  =
    reset_wait >> ssr_wake_shift(regs_q[IDX_STAB_TIME_SELECT][2:0]);
  wire logic             cnt_done   = (cnt_q == CNT_W'(1));
  wire logic             in_run     = (state_q == SSR_RUN);
  wire logic             in_stop    = (state_q == SSR_STOP);
  wire logic             in_rst     = (state_q == SSR_RESET_HOLD)
                                   || (state_q == SSR_STAB_RESET);
  wire logic             wake_end   = (state_q == SSR_STAB_WAKE) && cnt_done;
  wire logic             rst_end    = (state_q == SSR_STAB_RESET) && cnt_done;
  wire logic             svc_take   = irq_global_enable_in
                                   && (high_pri_q || in_service_priority_in);
  // Registers load reset values unless reset leaves stop; then at end of wait
  wire logic             reg_init   = (reset_req && !from_stop_d)
                                   || (rst_end && from_stop_q);

  // Bus decode
  wire logic             bus_req    = wb_cyc_in && wb_stb_in;
  wire logic [3:0]       bus_idx    = wb_adr_in[5:2];
  wire logic             bus_hit    = (wb_adr_in[ADR_W-1:6] == '0)
                                   && (bus_idx < 4'(REG_COUNT));
  wire logic             bus_wr     = bus_req && ack_q && wb_we_in && bus_hit
                                   && (bus_idx != IDX_STATUS);
  wire logic [15:0]      status_word = {9'h000, pend, !pin_sync_q, from_stop_q,
                                        1'b0, state_q};
  wire logic [15:0]      bus_rd     = !bus_hit ? 16'h0000
                                   : (bus_idx == IDX_STATUS) ? status_word
                                   : regs_q[bus_idx];

  // Next state
  always_comb begin
    state_d     = state_q;
    cnt_d       = (cnt_q > CNT_W'(1)) ? cnt_q - CNT_W'(1) : cnt_q;
    from_stop_d = from_stop_q;
    high_pri_d  = high_pri_q;
    if (reset_req) begin
      state_d = SSR_RESET_HOLD;
      if (!in_rst) begin
        from_stop_d = in_stop;
      end
    end else begin
      unique case (state_q)
        SSR_RUN: begin
          if (stop_ok) begin
            high_pri_d = pend_high;
            state_d    = pend ? SSR_STAB_WAKE : SSR_STOP;
            cnt_d      = wake_wait;
          end
        end
        SSR_STOP: begin
          if (pend) begin
            high_pri_d = pend_high;
            state_d    = SSR_STAB_WAKE;
            cnt_d      = wake_wait;
          end
        end
        SSR_STAB_WAKE: begin
          if (cnt_done) begin
            state_d = SSR_RUN;
          end
        end
        SSR_RESET_HOLD: begin
          state_d = SSR_STAB_RESET;
          cnt_d   = reset_wait;
        end
        SSR_STAB_RESET: begin
          if (cnt_done) begin
            state_d     = SSR_RUN;
            from_stop_d = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      pin_meta_q <= 1'b1;
      pin_sync_q <= 1'b1;
    end else if (clk_en_in) begin
      pin_meta_q <= ext_reset_n_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_q     <= SSR_STAB_RESET;
      cnt_q       <= CNT_W'(RESET_STAB_CYCLES);
      from_stop_q <= 1'b0;
      high_pri_q  <= 1'b0;
    end else if (clk_en_in) begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      from_stop_q <= from_stop_d;
      high_pri_q  <= high_pri_d;
    end
  end

  // Sequencing pulses
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      svc_q  <= 1'b0;
      next_q <= 1'b0;
      pcld_q <= 1'b0;
    end else if (clk_en_in) begin
      svc_q  <= !reset_req && wake_end && svc_take;
      next_q <= !reset_req && wake_end && !svc_take;
      pcld_q <= !reset_req && rst_end;
    end
  end

  // Register file
  always_ff @(posedge mclk_in) begin
    if (reset_in || (clk_en_in && reg_init)) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= ssr_reg_init(4'(i));
      end
    end else if (clk_en_in && bus_wr
                 && (in_run || bus_idx != IDX_PORT_LATCH)) begin
      if (wb_sel_in[0]) begin
        regs_q[bus_idx][7:0] <= wb_dat_in[7:0];
      end
      if (wb_sel_in[1] && (bus_idx == IDX_TIMER16_COUNT
                           || bus_idx == IDX_TIMER16_CAPCMP)) begin
        regs_q[bus_idx][15:8] <= wb_dat_in[15:8];
      end
    end
  end

  // Wishbone answer: ack one cycle after request, write at the ack edge
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else if (clk_en_in) begin
      ack_q  <= bus_req && !ack_q;
      rdat_q <= {16'h0000, bus_rd};
    end
  end

  assign wb_ack_out    = ack_q;
  assign wb_dat_out    = rdat_q;

  // Clock generator and pins
  assign main_osc_en_out  = !in_stop && (state_q != SSR_RESET_HOLD);
  assign sub_osc_en_out   = 1'b1;
  assign cpu_clk_en_out   = in_run;
  assign crystal_output_pin_pullup_out = in_stop;
  assign port_hiz_out     = in_rst;
  assign port_latch_out   = regs_q[IDX_PORT_LATCH][7:0];
  assign port_mode_out    = regs_q[IDX_PORT_MODE][7:0];

  // Peripheral enables: run state drives them all; 8-bit timers, watch and serial may also run in stop, ext irq detect runs outside reset
  assign timer16_run_out      = in_run;
  assign wdt_run_out          = in_run;
  assign adc_run_out          = in_run;
  assign uart_run_out         = in_run;
  assign vehicle_net_run_out  = in_run;
  assign sound_run_out        = in_run;
  assign lcd_run_out          = in_run;
  assign timer8_run_out       = {2{in_run}} | ({2{in_stop}} & timer5_ext_sel_in);
  assign watch_run_out        = in_run
                             || (in_stop && subclk_present_in && watch_sel_subclk_in);
  assign three_wire_serial_run_out = in_run || (in_stop && three_wire_serial_ext_clk_in);
  assign ext_irq_detect_en_out = !in_rst;

  assign core_reset_out        = in_rst;
  assign pc_load_out           = pcld_q;
  assign reset_vector_addr_out = RESET_VECTOR_ADDR;
  assign irq_service_out       = svc_q;
  assign next_instr_out        = next_q;

  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  stop_from_main_a: assert property (
    clk_en_in && in_run && stop_exec_in && cpu_on_subclk_in && !reset_req
    |=> cpu_clk_en_out && !crystal_output_pin_pullup_out)
    else $error("stop entered from subsystem clock");

  halt_fallback_a: assert property (
    clk_en_in && in_run && stop_ok && pend && !reset_req
    |=> !crystal_output_pin_pullup_out && !cpu_clk_en_out && main_osc_en_out)
    else $error("pending request did not fall back");

  stop_clocks_a: assert property (
    crystal_output_pin_pullup_out
    |-> !main_osc_en_out && sub_osc_en_out && !cpu_clk_en_out && !port_hiz_out)
    else $error("wrong clocks in stop");

  stop_periph_a: assert property (
    crystal_output_pin_pullup_out |-> !(timer16_run_out || wdt_run_out || adc_run_out
      || uart_run_out || vehicle_net_run_out || sound_run_out || lcd_run_out))
    else $error("peripheral running in stop");

  latch_hold_a: assert property (
    in_stop && clk_en_in && !reset_req |=> $stable(port_latch_out))
    else $error("port latch changed in stop");

  wake_wait_a: assert property (
    clk_en_in && in_stop && pend && !reset_req
    |=> !cpu_clk_en_out && (cnt_q == $past(wake_wait)))
    else $error("wake skipped stabilisation");

  service_run_a: assert property (
    $rose(irq_service_out) |-> cpu_clk_en_out && !next_instr_out
      && $past(irq_global_enable_in))
    else $error("service without enable");

  reset_hiz_a: assert property (
    clk_en_in && reset_req |=> port_hiz_out && !main_osc_en_out && core_reset_out)
    else $error("reset did not float pins");

  reset_wait_a: assert property (
    state_q == SSR_RESET_HOLD && clk_en_in && !reset_req
    |=> (cnt_q == reset_wait) && port_hiz_out)
    else $error("reset wait not loaded");

  vector_load_a: assert property (
    $rose(pc_load_out) |-> cpu_clk_en_out && $past(state_q == SSR_STAB_RESET))
    else $error("vector load out of sequence");

  ack_pulse_a: assert property (
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than a cycle");

  wake_count_a: assert property (
    clk_en_in && state_q == SSR_STAB_WAKE && !cnt_done && !reset_req
    |=> !cpu_clk_en_out)
    else $error("clock released before count end");

  next_action_a: assert property (
    $rose(next_instr_out) |-> cpu_clk_en_out && !irq_service_out)
    else $error("next instruction out of sequence");

  stop_reset_a: assert property (
    clk_en_in && in_stop && reset_req
    |=> port_hiz_out && $stable(port_latch_out))
    else $error("reset from stop lost contents");

endmodule

/* File: dv/ssr_cpu_model.sv */
`timescale 1ns/100ps
module ssr_cpu_model (
  // Clock
  input  wire logic       mclk_in,
  // Requests from the bench
  input  wire logic       stop_req_in,
  input  wire logic       wdt_req_in,
  input  wire logic       pin_req_in,
  // Sequencing from the block
  input  wire logic       cpu_clk_en_in,
  input  wire logic       pc_load_in,
  input  wire logic       irq_service_in,
  input  wire logic       next_instr_in,
  // Towards the block and the bench
  output logic            stop_exec_out = 1'b0,
  output logic            wdt_overflow_out = 1'b0,
  output logic            ext_reset_n_out = 1'b1,
  output logic [7:0]      pc_loads_out = 8'h00,
  output logic [7:0]      services_out = 8'h00,
  output logic [7:0]      nexts_out = 8'h00
);
  logic [10:0] pin_cnt_q = 11'h000;
  always @(posedge mclk_in) begin
    // A halted core executes no stop instruction
    stop_exec_out <= stop_req_in && cpu_clk_en_in;
    wdt_overflow_out <= wdt_req_in;
    if (pc_load_in)
      pc_loads_out <= pc_loads_out + 8'h01;
    if (irq_service_in)
      services_out <= services_out + 8'h01;
    if (next_instr_in)
      nexts_out <= nexts_out + 8'h01;
    if (pin_req_in && pin_cnt_q == 11'h000) begin
      pin_cnt_q <= 11'h3e8;
      ext_reset_n_out <= 1'b0;
    end else if (pin_cnt_q > 11'h001) begin
      pin_cnt_q <= pin_cnt_q - 11'h001;
    end else if (pin_cnt_q == 11'h001) begin
      pin_cnt_q <= 11'h000;
      ext_reset_n_out <= 1'b1;
    end
  end
endmodule

/* File: dv/stop_mode_and_reset_control_tb.sv */
`timescale 1ns/100ps
module stop_mode_and_reset_control_tb
  import ssr_pkg::*;
;
  localparam int STAB = 64;
  logic             mclk_in = 1'b0, reset_in = 1'b1, clk_en_in = 1'b1;
  logic             wb_cyc_in = 1'b0, wb_stb_in = 1'b0, wb_we_in = 1'b0, wb_ack_out;
  logic [ADR_W-1:0] wb_adr_in = '0;
  logic [3:0]       wb_sel_in = 4'h0;
  logic [31:0]      wb_dat_in = '0, wb_dat_out, rd;
  logic             ext_reset_n_in, wdt_overflow_in, stop_exec_in, cpu_on_subclk_in = 1'b0;
  logic [IRQ_N-1:0] irq_req_in = '0, irq_mask_flag_in = '1, irq_priority_flag_in = '1;
  logic             irq_global_enable_in = 1'b0, in_service_priority_in = 1'b0;
  logic [1:0]       timer5_ext_sel_in = 2'h0, timer8_run_out;
  logic             subclk_present_in = 1'b0, watch_sel_subclk_in = 1'b0;
  logic             three_wire_serial_ext_clk_in = 1'b0;
  logic             main_osc_en_out, sub_osc_en_out, cpu_clk_en_out, port_hiz_out;
  logic             crystal_output_pin_pullup_out, timer16_run_out, wdt_run_out, adc_run_out;
  logic             uart_run_out, vehicle_net_run_out, sound_run_out, lcd_run_out;
  logic             watch_run_out, three_wire_serial_run_out, ext_irq_detect_en_out;
  logic             core_reset_out, pc_load_out, irq_service_out, next_instr_out;
  logic [7:0]       port_latch_out, port_mode_out, pc_loads, services, nexts;
  logic [15:0]      reset_vector_addr_out;
  logic             stop_req = 1'b0, wdt_req = 1'b0, pin_req = 1'b0;
  int               miscompares = 0, checks = 0, n;
  logic [15:0]      exp_init [0:10] = '{16'h0004, 16'h0002, 16'h0004, 16'h00cf, 16'h000c,
                                        16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h00ff};

  always #5 mclk_in = ~mclk_in;

  ssr_stop_reset #(.RESET_STAB_CYCLES(STAB)) dut (
    .mclk_in, .reset_in, .clk_en_in, .wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_adr_in,
    .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .ext_reset_n_in, .wdt_overflow_in,
    .stop_exec_in, .cpu_on_subclk_in, .irq_req_in, .irq_mask_flag_in, .irq_priority_flag_in,
    .irq_global_enable_in, .in_service_priority_in, .timer5_ext_sel_in, .subclk_present_in,
    .watch_sel_subclk_in, .three_wire_serial_ext_clk_in, .main_osc_en_out, .sub_osc_en_out,
    .cpu_clk_en_out, .crystal_output_pin_pullup_out, .port_hiz_out, .port_latch_out,
    .port_mode_out, .timer16_run_out, .wdt_run_out, .adc_run_out, .uart_run_out,
    .vehicle_net_run_out, .sound_run_out, .lcd_run_out, .timer8_run_out, .watch_run_out,
    .three_wire_serial_run_out, .ext_irq_detect_en_out, .core_reset_out, .pc_load_out,
    .reset_vector_addr_out, .irq_service_out, .next_instr_out);

  ssr_cpu_model partner (
    .mclk_in, .stop_req_in(stop_req), .wdt_req_in(wdt_req), .pin_req_in(pin_req),
    .cpu_clk_en_in(cpu_clk_en_out), .pc_load_in(pc_load_out), .irq_service_in(irq_service_out),
    .next_instr_in(next_instr_out), .stop_exec_out(stop_exec_in),
    .wdt_overflow_out(wdt_overflow_in), .ext_reset_n_out(ext_reset_n_in),
    .pc_loads_out(pc_loads), .services_out(services), .nexts_out(nexts));

  task complete_run;
    if (miscompares == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tmo;
    miscompares++;
    complete_run();
  endtask

  task tick(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask

  task wb(input logic we, input logic [ADR_W-1:0] a, input logic [31:0] d,
          output logic [31:0] r);
    int w;
    @(posedge mclk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= a;
    wb_dat_in <= d;
    wb_sel_in <= 4'h3;
    w = 0;
    do begin
      @(posedge mclk_in);
      w++;
    end while (wb_ack_out !== 1'b1 && w < 20);
    r = wb_dat_out;
    if (w >= 20)
      tmo();
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in <= 1'b0;
  endtask

  // Counts cycles until the core clock returns
  task wait_run(input logic hiz);
    n = 0;
    while (cpu_clk_en_out !== 1'b1 && n < 2000) begin
      chk1(port_hiz_out, hiz);
      tick(1);
      n++;
    end
    if (n >= 2000)
      tmo();
  endtask

  task do_stop;
    @(posedge mclk_in);
    stop_req <= 1'b1;
    @(posedge mclk_in);
    stop_req <= 1'b0;
    tick(3);
  endtask

  task t_reset_values;
    for (int i = 0; i < 11; i++) begin
      wb(1'b0, ADR_W'(i * 4), '0, rd);
      chk32(rd, {16'h0000, exp_init[i]});
    end
    chk32({24'h00_0000, port_mode_out}, 32'h0000_00ff);
    chk32({16'h0000, reset_vector_addr_out}, 32'h0000_0000);
    wb(1'b1, 8'h40, 32'h0000_00ff, rd);
    wb(1'b0, 8'h40, '0, rd);
    chk32(rd, 32'h0000_0000);
  endtask

  task t_stop_refused;
    cpu_on_subclk_in <= 1'b1;
    do_stop();
    chk1(cpu_clk_en_out, 1'b1);
    chk1(crystal_output_pin_pullup_out, 1'b0);
    @(posedge mclk_in);
    cpu_on_subclk_in <= 1'b0;
  endtask

  task t_stop_state;
    wb(1'b1, 8'h24, 32'h0000_00a5, rd);
    timer5_ext_sel_in <= 2'h1;
    subclk_present_in <= 1'b1;
    watch_sel_subclk_in <= 1'b1;
    three_wire_serial_ext_clk_in <= 1'b1;
    do_stop();
    chk1(crystal_output_pin_pullup_out, 1'b1);
    chk32({29'h0, main_osc_en_out, sub_osc_en_out, cpu_clk_en_out}, 32'h2);
    wb(1'b1, 8'h24, 32'h0000_0011, rd);
    tick(1);
    chk32({24'h00_0000, port_latch_out}, 32'h0000_00a5);
    chk1(timer16_run_out | wdt_run_out | adc_run_out | uart_run_out, 1'b0);
    chk1(vehicle_net_run_out | sound_run_out | lcd_run_out, 1'b0);
    chk32({30'h0, timer8_run_out}, 32'h1);
    chk1(watch_run_out, 1'b1);
    chk1(three_wire_serial_run_out & ext_irq_detect_en_out, 1'b1);
    @(posedge mclk_in);
    subclk_present_in <= 1'b0;
    timer5_ext_sel_in <= 2'h2;
    three_wire_serial_ext_clk_in <= 1'b0;
    tick(2);
    chk1(watch_run_out, 1'b0);
    chk32({30'h0, timer8_run_out}, 32'h2);
    chk1(three_wire_serial_run_out, 1'b0);
    @(posedge mclk_in);
    irq_req_in <= 8'h01;
    irq_mask_flag_in <= 8'hfe;
    wait_run(1'b0);
    @(posedge mclk_in);
    irq_req_in <= '0;
    irq_mask_flag_in <= '1;
  endtask

  task wake_case(input logic [2:0] sel, input logic prio, input logic ie, input logic in_service_priority,
                 input logic svc, input int wexp);
    logic [7:0] s0, n0;
    wb(1'b1, 8'h00, {29'h0, sel}, rd);
    irq_priority_flag_in <= {IRQ_N{prio}};
    irq_global_enable_in <= ie;
    in_service_priority_in <= in_service_priority;
    do_stop();
    chk1(cpu_clk_en_out, 1'b0);
    @(posedge mclk_in);
    irq_req_in <= 8'h01;
    tick(4);
    chk1(crystal_output_pin_pullup_out, 1'b1);
    s0 = services;
    n0 = nexts;
    @(posedge mclk_in);
    irq_mask_flag_in <= 8'hfe;
    wait_run(1'b0);
    chk1(n >= wexp - 3 && n <= wexp + 3, 1'b1);
    tick(2);
    chk32({24'h00_0000, 8'(services - s0)}, {31'h0, svc});
    chk32({24'h00_0000, 8'(nexts - n0)}, {31'h0, ~svc});
    @(posedge mclk_in);
    irq_req_in <= '0;
    irq_mask_flag_in <= '1;
  endtask

  task t_pending_at_stop;
    @(posedge mclk_in);
    irq_req_in <= 8'h01;
    irq_mask_flag_in <= 8'hfe;
    do_stop();
    chk1(crystal_output_pin_pullup_out, 1'b0);
    chk1(main_osc_en_out & ~cpu_clk_en_out, 1'b1);
    wait_run(1'b0);
    @(posedge mclk_in);
    irq_req_in <= '0;
    irq_mask_flag_in <= '1;
  endtask

  task t_wdt_reset;
    wb(1'b1, 8'h24, 32'h0000_005a, rd);
    wdt_req <= 1'b1;
    @(posedge mclk_in);
    wdt_req <= 1'b0;
    tick(3);
    chk1(core_reset_out & port_hiz_out, 1'b1);
    wait_run(1'b1);
    chk1(n >= STAB - 5 && n <= STAB + 2, 1'b1);
    wb(1'b0, 8'h24, '0, rd);
    chk32(rd, 32'h0000_0000);
  endtask

  task t_pin_in_stop;
    int w;
    wb(1'b1, 8'h24, 32'h0000_00a5, rd);
    do_stop();
    @(posedge mclk_in);
    pin_req <= 1'b1;
    @(posedge mclk_in);
    pin_req <= 1'b0;
    tick(5);
    chk1(port_hiz_out, 1'b1);
    chk32({30'h0, main_osc_en_out, sub_osc_en_out}, 32'h1);
    chk32({24'h00_0000, port_latch_out}, 32'h0000_00a5);
    wb(1'b0, 8'h2c, '0, rd);
    chk32(rd, 32'h0000_0033);
    w = 0;
    while (ext_reset_n_in !== 1'b1 && w < 1100) begin
      tick(1);
      w++;
    end
    if (w >= 1100)
      tmo();
    wait_run(1'b1);
    chk1(n >= STAB - 4 && n <= STAB + 4, 1'b1);
    wb(1'b0, 8'h24, '0, rd);
    chk32(rd, 32'h0000_0000);
  endtask

  initial begin
    repeat (5) @(posedge mclk_in);
    reset_in <= 1'b0;
    tick(1);
    wait_run(1'b1);
    chk1(n >= STAB - 4 && n <= STAB + 2, 1'b1);
    tick(2);
    chk32({24'h00_0000, pc_loads}, 32'h0000_0001);
    t_reset_values();
    t_stop_refused();
    t_stop_state();
    wake_case(3'h4, 1'b1, 1'b1, 1'b0, 1'b0, STAB);
    wake_case(3'h0, 1'b0, 1'b1, 1'b0, 1'b1, 2);
    wake_case(3'h0, 1'b1, 1'b1, 1'b1, 1'b1, 2);
    wake_case(3'h1, 1'b0, 1'b0, 1'b1, 1'b0, 8);
    t_pending_at_stop();
    t_wdt_reset();
    t_pin_in_stop();
    complete_run();
  end
endmodule
